// ==== include/prog_io_pkg.sv ====
// Constants for the programmable pin block: handles, reset values, timing
package prog_io_pkg;
  // Attribute handles of the registers
  localparam logic [15:0] H_DIR        = 16'h0017;
  localparam logic [15:0] H_OUT        = 16'h001a;
  localparam logic [15:0] H_IN         = 16'h001d;
  localparam logic [15:0] H_A_FIRST    = 16'h0021;
  localparam logic [15:0] H_A_SECOND   = 16'h0024;
  localparam logic [15:0] H_B_FIRST    = 16'h0027;
  localparam logic [15:0] H_B_SECOND   = 16'h002a;
  // Reset values
  localparam logic [7:0]  DIR_RESET    = 8'h00;
  localparam logic [7:0]  OUT_RESET    = 8'hbf;
  localparam logic [5:0]  IN_RESET     = 6'h3f;
  localparam logic [31:0] DELAY_RESET  = 32'h0000_0000;
  localparam logic [7:0]  PIN_OUT_RESET = 8'hff;
  localparam logic [7:0]  PIN_OEB_RESET = 8'h3f;
  // Field positions and the save command value
  localparam int          LOW_PINS     = 6;
  localparam int          LINK_PIN     = 6;
  localparam int          SLEEP_PIN    = 7;
  localparam logic [7:0]  SAVE_CMD_VALUE = 8'h01;
  // Millisecond time base
  localparam int          MS_NS        = 1000000;
  localparam int          CLK_NS       = 25;
  localparam int          MS_TICK_CYCLES = MS_NS / CLK_NS;
endpackage

// ==== logic/toggle_timer.sv ====
// Dual-delay timed toggle generator for one upper pin
`timescale 1ns/1ps
module toggle_timer
  import prog_io_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Control
  input  wire logic        msTick,
  input  wire logic        enable,
  input  wire logic        writeFirst,
  input  wire logic        writeSecond,
  input  wire logic [31:0] wdata,
  // Status
  output logic      [31:0] firstDelay,
  output logic      [31:0] secondDelay,
  output logic             toggling,
  output logic             flip
);
  typedef struct packed {
    logic        active;
    logic        inSecond;
    logic        flip;
    logic [31:0] first;
    logic [31:0] second;
    logic [31:0] count;
  } timer_t;

  timer_t s_q;
  timer_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.flip = 1'b0;
    if (msTick && s_q.active)
    begin
      if (s_q.count == 32'h0000_0001)
      begin
        s_d.flip = 1'b1;
        if (s_q.second == 32'h0000_0000)
          s_d.active = 1'b0;
        else
        begin
          s_d.inSecond = ~s_q.inSecond;
          s_d.count = s_q.inSecond ? s_q.first : s_q.second;
        end
      end
      else
        s_d.count = s_q.count - 32'h0000_0001;
    end
    // Storing the second delay never starts the generator
    if (writeSecond)
      s_d.second = wdata;
    if (writeFirst)
    begin
      s_d.first = wdata;
      if (wdata == 32'h0000_0000)
      begin
        s_d.active = 1'b0;
        s_d.flip = 1'b0;
        s_d.second = DELAY_RESET;
      end
      else if (enable)
      begin
        s_d.active = 1'b1;
        s_d.inSecond = 1'b0;
        s_d.count = wdata;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.active   <= 1'b0;
      s_q.inSecond <= 1'b0;
      s_q.flip     <= 1'b0;
      s_q.first    <= DELAY_RESET;
      s_q.second   <= DELAY_RESET;
      s_q.count    <= DELAY_RESET;
    end
    else
      s_q <= s_d;
  end

  assign firstDelay  = s_q.first;
  assign secondDelay = s_q.second;
  assign toggling    = s_q.active;
  assign flip        = s_q.flip;

  oneShot_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.flip && (s_q.second == 32'h0000_0000) |-> !s_q.active)
    else $error("one-shot toggle kept running");
  stopClear_a: assert property (@(posedge clock) disable iff (!rst_b)
    writeFirst && (wdata == 32'h0000_0000)
      |=> !s_q.active && !s_q.flip && (s_q.second == 32'h0000_0000))
    else $error("zero first delay did not stop toggling");
  noStart_a: assert property (@(posedge clock) disable iff (!rst_b)
    !s_q.active && writeFirst && !enable |=> !s_q.active)
    else $error("toggling started while pin not a general output");
endmodule // toggle_timer

// ==== logic/prog_io.sv ====
// Eight-pin programmable I/O block with indicators and timed toggling
// Functional notes
// - Direction bits 5..0: one makes the lower pin an output, zero an input.
// - Sleep indicator pin reads 0 while awake, 1 while sleeping.
// - Link indicator pin reads 0 while connected, 1 while disconnected.
// - Upper pins are never inputs; their input status bits mean nothing.
// - Output-level bits reach a pin only while it is an output.
// - Level bits 7 and 6 matter only in general-output mode.
// - Output-level register resets to hex BF.
// - Direction register resets to zero: indicators up, inputs below.
// - Input byte shows lower pin levels; notify on input pin change when enabled.
// - Settings are saved only on save command; pin 0 is never saved.
// - Timed toggling works only while the direction bit is one.
// - Non-zero first delay starts toggling; zero leaves it off.
// - Zero second delay gives one inversion; otherwise delays alternate forever.
// - Writing zero first delay stops at once, holds level, clears second delay.
// - Delays are unsigned 32-bit millisecond counts over the full range.
// - Periodic toggling from high: high for first delay, low for second.
// - While toggling, level writes and return to indicator mode are ignored.
// - Second upper pin has its own identical pair of delay registers.
// - All four delay registers reset to zero, toggling idle.
`timescale 1ns/1ps
module prog_io
  import prog_io_pkg::*;
#(
  parameter int MS_TICKS = MS_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Attribute access from the remote host application
  input  wire logic        attrWrite,
  input  wire logic        attrRead,
  input  wire logic [15:0] attrHandle,
  input  wire logic [31:0] attrWdata,
  output logic      [31:0] attrRdata,
  output logic             attrRvalid,
  // Input change notification
  input  wire logic        inputNotifySwitch,
  output logic             notifyValid,
  output logic      [7:0]  notifyByte,
  // Settings save command and saved image
  input  wire logic        saveCmdValid,
  input  wire logic [7:0]  saveCmdValue,
  output logic             saveValid,
  output logic      [13:0] saveImage,
  // System status for the indicators
  input  wire logic        sleeping,
  input  wire logic        connected,
  // Pins
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOe_b
);
  typedef struct packed {
    logic [7:0]  dir;
    logic [7:0]  outLvl;
    logic [5:0]  inLvl;
    logic [31:0] rdata;
    logic        rvalid;
    logic        notifyValid;
    logic [7:0]  notifyByte;
    logic        saveValid;
    logic [13:0] saveImage;
    logic [7:0]  pinOut;
    logic [7:0]  pinOeB;
    logic [31:0] msCnt;
    logic        msTick;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [31:0] firstDelay  [2];
  logic [31:0] secondDelay [2];
  logic [1:0]  toggling;
  logic [1:0]  flip;
  logic [5:0]  inChanged;

  // Index 0 serves the link pin, index 1 the sleep pin
  for (genvar i = 0; i < 2; i++)
  begin : g_timer
    localparam logic [15:0] H_FIRST  = (i == 0) ? H_A_FIRST : H_B_FIRST;
    localparam logic [15:0] H_SECOND = (i == 0) ? H_A_SECOND : H_B_SECOND;
    toggle_timer u_timer (
      .clock       (clock),
      .rst_b       (rst_b),
      .msTick      (s_q.msTick),
      .enable      (s_q.dir[LINK_PIN + i]),
      .writeFirst  (attrWrite && (attrHandle == H_FIRST)),
      .writeSecond (attrWrite && (attrHandle == H_SECOND)),
      .wdata       (attrWdata),
      .firstDelay  (firstDelay[i]),
      .secondDelay (secondDelay[i]),
      .toggling    (toggling[i]),
      .flip        (flip[i])
    );
  end

  // Only pins configured as inputs count as a change
  assign inChanged = (pinIn[5:0] ^ s_q.inLvl) & ~s_q.dir[5:0];

  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.notifyValid = 1'b0;
    s_d.saveValid = 1'b0;
    s_d.msTick = 1'b0;

    // Millisecond time base
    if (s_q.msCnt == 32'(MS_TICKS - 1))
    begin
      s_d.msCnt = 32'h0000_0000;
      s_d.msTick = 1'b1;
    end
    else
      s_d.msCnt = s_q.msCnt + 32'h0000_0001;

    // Register writes
    if (attrWrite && (attrHandle == H_DIR))
    begin
      s_d.dir = attrWdata[7:0];
      for (int j = 0; j < 2; j++)
        if (toggling[j])
          s_d.dir[LINK_PIN + j] = s_q.dir[LINK_PIN + j];
    end
    if (attrWrite && (attrHandle == H_OUT))
    begin
      s_d.outLvl = attrWdata[7:0];
      for (int j = 0; j < 2; j++)
        if (toggling[j])
          s_d.outLvl[LINK_PIN + j] = s_q.outLvl[LINK_PIN + j];
    end
    for (int j = 0; j < 2; j++)
      if (flip[j])
        s_d.outLvl[LINK_PIN + j] = ~s_q.outLvl[LINK_PIN + j];

    // Register reads; the output-level register is write-only
    if (attrRead)
    begin
      s_d.rvalid = 1'b1;
      unique case (attrHandle)
        H_DIR:      s_d.rdata = {24'h00_0000, s_q.dir};
        H_IN:       s_d.rdata = {26'h000_0000, s_q.inLvl};
        H_A_FIRST:  s_d.rdata = firstDelay[0];
        H_A_SECOND: s_d.rdata = secondDelay[0];
        H_B_FIRST:  s_d.rdata = firstDelay[1];
        H_B_SECOND: s_d.rdata = secondDelay[1];
        default:    s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Input sampling and change notification
    s_d.inLvl = pinIn[5:0];
    if (inputNotifySwitch && (|inChanged))
    begin
      s_d.notifyValid = 1'b1;
      s_d.notifyByte = {2'b00, pinIn[5:0]};
    end

    // Save hands out the upper seven pins only; pin 0 must stay an input
    if (saveCmdValid && (saveCmdValue == SAVE_CMD_VALUE))
    begin
      s_d.saveValid = 1'b1;
      s_d.saveImage = {s_d.dir[7:1], s_d.outLvl[7:1]};
    end

    // Pin drive, registered so every pin change comes from a flop
    for (int k = 0; k < LOW_PINS; k++)
    begin
      s_d.pinOeB[k] = ~s_d.dir[k];
      s_d.pinOut[k] = s_d.outLvl[k];
    end
    s_d.pinOeB[SLEEP_PIN:LINK_PIN] = 2'b00;
    s_d.pinOut[LINK_PIN] = s_d.dir[LINK_PIN] ? s_d.outLvl[LINK_PIN]
                                             : ~connected;
    s_d.pinOut[SLEEP_PIN] = s_d.dir[SLEEP_PIN] ? s_d.outLvl[SLEEP_PIN]
                                               : sleeping;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q.dir         <= DIR_RESET;
      s_q.outLvl      <= OUT_RESET;
      s_q.inLvl       <= IN_RESET;
      s_q.rdata       <= 32'h0000_0000;
      s_q.rvalid      <= 1'b0;
      s_q.notifyValid <= 1'b0;
      s_q.notifyByte  <= 8'h00;
      s_q.saveValid   <= 1'b0;
      s_q.saveImage   <= 14'h0000;
      s_q.pinOut      <= PIN_OUT_RESET;
      s_q.pinOeB      <= PIN_OEB_RESET;
      s_q.msCnt       <= 32'h0000_0000;
      s_q.msTick      <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign attrRdata   = s_q.rdata;
  assign attrRvalid  = s_q.rvalid;
  assign notifyValid = s_q.notifyValid;
  assign notifyByte  = s_q.notifyByte;
  assign saveValid   = s_q.saveValid;
  assign saveImage   = s_q.saveImage;
  assign pinOut      = s_q.pinOut;
  assign pinOe_b     = s_q.pinOeB;

  // The first edge after release still shows the reset drive, not the status inputs
  linkIndicator_a: assert property (@(posedge clock) disable iff (!rst_b)
    $past(rst_b) && !s_q.dir[LINK_PIN] |-> s_q.pinOut[LINK_PIN] == ~$past(connected))
    else $error("link indicator level wrong");
  sleepIndicator_a: assert property (@(posedge clock) disable iff (!rst_b)
    $past(rst_b) && !s_q.dir[SLEEP_PIN] |-> s_q.pinOut[SLEEP_PIN] == $past(sleeping))
    else $error("sleep indicator level wrong");
  upperDriven_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.pinOeB[SLEEP_PIN:LINK_PIN] == 2'b00)
    else $error("upper pin released");
  lowerDir_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.pinOeB[5:0] == ~s_q.dir[5:0])
    else $error("lower pin direction mismatch");
  generalOut_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.dir[LINK_PIN] |-> s_q.pinOut[LINK_PIN] == s_q.outLvl[LINK_PIN])
    else $error("general output level not applied");
  togglingLock_a: assert property (@(posedge clock) disable iff (!rst_b)
    toggling[0] && attrWrite && (attrHandle == H_DIR) |=> s_q.dir[LINK_PIN])
    else $error("indicator mode entered while toggling");
  inputNotify_a: assert property (@(posedge clock) disable iff (!rst_b)
    inputNotifySwitch && (|inChanged)
      |=> s_q.notifyValid && (s_q.notifyByte[5:0] == $past(pinIn[5:0])))
    else $error("input change not notified");
  msTickWrap_a: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.msTick |-> (s_q.msCnt == 32'h0000_0000) ##1 !s_q.msTick)
    else $error("millisecond tick misplaced");
endmodule // prog_io

// ==== dv/ext_circuits.sv ====
// External circuits on the eight pins: they follow driven pins and drive released ones
`timescale 1ns/1ps
module ext_circuits
(
  // Device side of the pins
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe_b,
  // Levels the outside world puts on released lower pins
  input  wire logic [5:0] extLevel,
  output logic      [7:0] pinIn
);
  // Upper pins are never released, so the wire always carries the device drive
  assign pinIn[7:6] = pinOut[7:6];
  // A driven lower pin shows the device level, a released one the outside level
  assign pinIn[5:0] = (pinOe_b[5:0] & extLevel) | (~pinOe_b[5:0] & pinOut[5:0]);
endmodule // ext_circuits

// ==== dv/programmable_io_with_timed_toggle_bench.sv ====
// Self-checking bench for the programmable pin block
`timescale 1ns/1ps
module programmable_io_with_timed_toggle_bench import prog_io_pkg::*; ();
  // Short millisecond so timed toggling runs in a few hundred cycles
  localparam int MT = 10;
  logic        clock, rst_b, attrWrite, attrRead, inputNotifySwitch, saveCmdValid;
  logic        sleeping, connected, attrRvalid, notifyValid, saveValid;
  logic [15:0] attrHandle;
  logic [31:0] attrWdata, attrRdata, seed;
  logic [7:0]  saveCmdValue, notifyByte, pinIn, pinOut, pinOe_b;
  logic [5:0]  extLevel;
  logic [13:0] saveImage;
  logic [31:0] expRd[$], expNt[$], expSv[$];
  logic [15:0] hs [4] = '{H_A_FIRST, H_A_SECOND, H_B_FIRST, H_B_SECOND};
  int          fail_count, cmp_count, n;

  prog_io #(.MS_TICKS(MT)) dut (.clock(clock), .rst_b(rst_b), .attrWrite(attrWrite),
    .attrRead(attrRead), .attrHandle(attrHandle), .attrWdata(attrWdata),
    .attrRdata(attrRdata), .attrRvalid(attrRvalid), .inputNotifySwitch(inputNotifySwitch),
    .notifyValid(notifyValid), .notifyByte(notifyByte), .saveCmdValid(saveCmdValid),
    .saveCmdValue(saveCmdValue), .saveValid(saveValid), .saveImage(saveImage),
    .sleeping(sleeping), .connected(connected), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe_b(pinOe_b));
  ext_circuits ext (.pinOut(pinOut), .pinOe_b(pinOe_b), .extLevel(extLevel), .pinIn(pinIn));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One register access; a read notes its expected answer for the monitor
  task automatic acc(input logic rd, input logic [15:0] h, input logic [31:0] d);
    @(posedge clock);
    attrRead   <= rd;
    attrWrite  <= !rd;
    attrHandle <= h;
    attrWdata  <= d;
    if (rd)
      expRd.push_back(d);
    @(posedge clock);
    attrRead  <= 1'b0;
    attrWrite <= 1'b0;
  endtask

  // Counts cycles until pin b changes, giving up after lim
  task automatic waitFlip(input int b, input int lim);
    logic v;
    v = pinOut[b];
    n = 0;
    while (pinOut[b] === v && n < lim)
    begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic conclude;
    check(expRd.size() + expNt.size() + expSv.size(), 0);
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // An answer with no note left is a mismatch too
  always @(negedge clock)
  begin
    if (attrRvalid === 1'b1)
      check(attrRdata, expRd.size() ? expRd.pop_front() : 32'hdead_beef);
    if (notifyValid === 1'b1)
      check(notifyByte, expNt.size() ? expNt.pop_front() : 32'hdead_beef);
    if (saveValid === 1'b1)
      check(saveImage, expSv.size() ? expSv.pop_front() : 32'hdead_beef);
  end

  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    conclude();
  end

  initial
  begin
    {rst_b, attrWrite, attrRead, inputNotifySwitch, saveCmdValid} = 5'h00;
    attrHandle = 16'h0000;
    attrWdata = 32'h0000_0000;
    saveCmdValue = 8'h00;
    sleeping = 1'b0;
    connected = 1'b1;
    extLevel = 6'h3f;
    seed = 32'h59911b66;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    check(pinOe_b, PIN_OEB_RESET);
    acc(1, H_DIR, DIR_RESET);
    acc(1, H_IN, 32'h3f);
    acc(1, H_OUT, 32'h0);
    acc(1, 16'h0030, 32'h0);
    for (int i = 0; i < 4; i++)
      acc(1, hs[i], DELAY_RESET);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      seed = xs(seed);
      sleeping  <= seed[0];
      connected <= seed[1];
      repeat (3) @(negedge clock);
      check(pinOut[7:6], {seed[0], ~seed[1]});
    end
    @(posedge clock);
    inputNotifySwitch <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      seed = xs(seed);
      extLevel <= extLevel ^ (seed[5:0] | 6'h01);
      expNt.push_back({26'h0, extLevel ^ (seed[5:0] | 6'h01)});
      repeat (4) @(posedge clock);
    end
    inputNotifySwitch <= 1'b0;
    acc(1, H_IN, {26'h0, extLevel});
    acc(0, H_DIR, 32'hff);
    repeat (2) @(negedge clock);
    check(pinOut, OUT_RESET);
    check(pinOe_b, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      acc(0, H_DIR, {24'h0, 2'b11, seed[13:8]});
      acc(0, H_OUT, {24'h0, seed[7:0]});
      repeat (2) @(negedge clock);
      check(pinOe_b, {2'b00, ~seed[13:8]});
      check(pinOut & ~pinOe_b, seed[7:0] & {2'b11, seed[13:8]});
    end
    acc(0, H_DIR, 32'h00);
    acc(0, H_OUT, 32'h00);
    repeat (2) @(negedge clock);
    check(pinOut[7:6], {sleeping, ~connected});
    acc(0, H_DIR, 32'hc0);
    repeat (2) @(negedge clock);
    check(pinOut[7:6], 2'b00);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      saveCmdValid <= 1'b1;
      saveCmdValue <= i ? SAVE_CMD_VALUE : 8'h02;
      if (i)
        expSv.push_back({7'h60, 7'h00});
      @(posedge clock);
      saveCmdValid <= 1'b0;
    end
    acc(0, H_OUT, 32'hff);
    acc(0, H_A_SECOND, 32'd3);
    waitFlip(6, 40);
    check(n, 40);
    acc(0, H_A_FIRST, 32'd2);
    waitFlip(6, 40);
    check(pinOut[6], 1'b0);
    waitFlip(6, 100);
    check(n, 3 * MT);
    waitFlip(6, 100);
    check(n, 2 * MT);
    acc(0, H_DIR, 32'h00);
    acc(1, H_DIR, 32'h40);
    acc(0, H_A_FIRST, 32'h0);
    acc(1, H_A_SECOND, 32'h0);
    waitFlip(6, 80);
    check(n, 80);
    acc(0, H_A_SECOND, 32'hffff_ffff);
    acc(1, H_A_SECOND, 32'hffff_ffff);
    acc(0, H_B_FIRST, 32'd2);
    waitFlip(7, 60);
    check(n, 60);
    acc(0, H_B_FIRST, 32'h0);
    acc(0, H_DIR, 32'hc0);
    acc(0, H_B_FIRST, 32'd2);
    waitFlip(7, 40);
    check(pinOut[7], 1'b0);
    waitFlip(7, 100);
    check(n, 100);
    conclude();
  end
endmodule // programmable_io_with_timed_toggle_bench
